//--- verilog/sb_bridge_end.sv
// Bridge end: request FIFO and secondary bus initiator with idle parking
// Operation
// R01 - Address at frame start, data in later phases
// R02 - Write data held stable while initiator ready
// R03 - Word moves only when both readies asserted
// R04 - Idle with grant: drive address/data lines
// R05 - Address phase carries command code on lines
// R06 - Data phases carry byte-lane enables instead
// R07 - Idle with grant: drive command/byte-lane lines
// R08 - Parity makes lines plus parity even
// R09 - Release lines when neither parked nor driving
`timescale 1ns/1ps
module sb_fifo
	import sb_pkg::*;
#(
	parameter int WIDTH = SB_FIFO_W,
	parameter int DEPTH = SB_FIFO_D
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb
	begin
		push        = in_valid_i && in_ready_o;
		pop         = out_ready_i && out_valid_o;
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count  = count;
		if (push && !pop)
			next_count = (AW+1)'(count + 1'b1);
		else if (pop && !push)
			next_count = (AW+1)'(count - 1'b1);
	end

	// Flags are registered so in_ready_o and out_valid_o come straight from flops
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			count       <= '0;
			in_ready_o  <= 1'b0;
			out_valid_o <= 1'b0;
		end
		else
		begin
			wr_ptr      <= next_wr_ptr;
			rd_ptr      <= next_rd_ptr;
			count       <= next_count;
			in_ready_o  <= (next_count != (AW+1)'(DEPTH));
			out_valid_o <= (next_count != '0);
		end
	end
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			store[wr_ptr] <= in_data_i;
	end
	assign out_data_o = store[rd_ptr];
endmodule : sb_fifo

module sb_bridge_end
	import sb_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	sb_bus_if.bridge         bus,
	input  wire logic        park_grant_i,
	input  wire logic        req_valid_i,
	output logic             req_ready_o,
	input  wire logic        req_write_i,
	input  wire logic [31:0] req_addr_i,
	input  wire logic [31:0] req_data_i,
	input  wire logic [3:0]  req_byte_lane_n_i,
	output logic             done_o,
	output logic             done_error_o,
	output logic [31:0]      rd_data_o
);
	typedef enum logic [1:0] {
		SB_ST_IDLE = 2'b00,
		SB_ST_ADDR = 2'b01,
		SB_ST_DATA = 2'b10,
		SB_ST_TURN = 2'b11
	} sb_state_t;

	sb_state_t            state;
	sb_state_t            next_state;
	logic                 fifo_valid;
	logic                 fifo_pop;
	logic [SB_FIFO_W-1:0] fifo_word;
	logic                 cur_write;
	logic [31:0]          cur_data;
	logic [3:0]           cur_be_n;
	logic [2:0]           wait_cnt;
	logic                 next_cur_write;
	logic [31:0]          next_cur_data;
	logic [3:0]           next_cur_be_n;
	logic [2:0]           next_wait_cnt;
	logic [31:0]          next_ad;
	logic                 next_ad_oe;
	logic [3:0]           next_cbe;
	logic                 next_cbe_oe;
	logic                 next_par;
	logic                 next_par_oe;
	logic                 next_frame_n;
	logic                 next_frame_oe;
	logic                 next_irdy_n;
	logic                 next_irdy_oe;
	logic                 next_done;
	logic                 next_done_error;
	logic [31:0]          next_rd_data;
	logic                 bus_idle;
	logic                 moved;

	sb_fifo #(
		.WIDTH (SB_FIFO_W),
		.DEPTH (SB_FIFO_D)
	) u_req_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (req_valid_i),
		.in_ready_o  (req_ready_o),
		.in_data_i   ({req_write_i, req_addr_i, req_data_i, req_byte_lane_n_i}),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_word)
	);

	always_comb
	begin
		bus_idle        = bus.frame_n && bus.secondary_initiator_ready_n;
		moved           = !bus.secondary_initiator_ready_n && !bus.secondary_target_ready_n; // R03
		fifo_pop        = (state == SB_ST_IDLE) && park_grant_i && bus_idle && fifo_valid;
		next_state      = state;
		next_cur_write  = cur_write;
		next_cur_data   = cur_data;
		next_cur_be_n   = cur_be_n;
		next_wait_cnt   = wait_cnt;
		next_ad         = bus.br_ad;
		next_ad_oe      = bus.br_ad_oe;
		next_cbe        = bus.br_cbe;
		next_cbe_oe     = bus.br_cbe_oe;
		next_frame_n    = bus.br_frame_n;
		next_frame_oe   = bus.br_frame_oe;
		next_irdy_n     = bus.br_irdy_n;
		next_irdy_oe    = bus.br_irdy_oe;
		next_done       = 1'b0;
		next_done_error = 1'b0;
		next_rd_data    = rd_data_o;
		// Parity trails the lines it covers by one cycle, driven if we drove them
		next_par        = ^{bus.br_ad, bus.br_cbe}; // R08
		next_par_oe     = bus.br_ad_oe;
		unique case (state)
			SB_ST_IDLE, SB_ST_TURN:
			begin
				next_state    = SB_ST_IDLE;
				next_ad       = SB_PARK_AD;
				next_ad_oe    = park_grant_i; // R04 R09
				next_cbe      = SB_PARK_CBE;
				next_cbe_oe   = park_grant_i; // R07 R09
				next_frame_n  = 1'b1;
				next_frame_oe = 1'b0;
				next_irdy_n   = 1'b1;
				next_irdy_oe  = 1'b0;
				if (fifo_pop)
				begin
					next_state     = SB_ST_ADDR;
					next_cur_write = fifo_word[SB_REQ_WR_BIT];
					next_cur_data  = fifo_word[SB_REQ_DAT_LSB +: 32];
					next_cur_be_n  = fifo_word[SB_REQ_BE_LSB +: 4];
					next_ad        = fifo_word[SB_REQ_ADR_LSB +: 32]; // R01
					next_ad_oe     = 1'b1;
					next_cbe       = fifo_word[SB_REQ_WR_BIT] ? SB_CMD_MEM_WR : SB_CMD_MEM_RD; // R05
					next_cbe_oe    = 1'b1;
					next_frame_n   = 1'b0;
					next_frame_oe  = 1'b1;
					next_irdy_oe   = 1'b1;
				end
			end
			SB_ST_ADDR:
			begin
				// Single data phase: frame goes high as initiator ready goes low
				next_state    = SB_ST_DATA;
				next_wait_cnt = '0;
				next_frame_n  = 1'b1;
				next_irdy_n   = 1'b0;
				next_cbe      = cur_be_n; // R06
				next_ad       = cur_data; // R01
				next_ad_oe    = cur_write; // R09
			end
			SB_ST_DATA:
			begin
				// Lines stay untouched while waiting, so write data holds
				next_wait_cnt = 3'(wait_cnt + 1'b1); // R02
				if (moved || wait_cnt == SB_WAIT_LIMIT)
				begin
					next_state      = SB_ST_TURN;
					next_irdy_n     = 1'b1;
					next_ad_oe      = 1'b0; // R09
					next_cbe_oe     = 1'b0;
					next_done       = 1'b1;
					next_done_error = !moved;
					if (moved && !cur_write)
						next_rd_data = bus.ad; // R03
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state           <= SB_ST_IDLE;
			cur_write       <= 1'b0;
			cur_data        <= '0;
			cur_be_n        <= '0;
			wait_cnt        <= '0;
			bus.br_ad       <= '0;
			bus.br_ad_oe    <= 1'b0;
			bus.br_cbe      <= '0;
			bus.br_cbe_oe   <= 1'b0;
			bus.br_par      <= 1'b0;
			bus.br_par_oe   <= 1'b0;
			bus.br_frame_n  <= 1'b1;
			bus.br_frame_oe <= 1'b0;
			bus.br_irdy_n   <= 1'b1;
			bus.br_irdy_oe  <= 1'b0;
			done_o          <= 1'b0;
			done_error_o    <= 1'b0;
			rd_data_o       <= '0;
		end
		else
		begin
			state           <= next_state;
			cur_write       <= next_cur_write;
			cur_data        <= next_cur_data;
			cur_be_n        <= next_cur_be_n;
			wait_cnt        <= next_wait_cnt;
			bus.br_ad       <= next_ad;
			bus.br_ad_oe    <= next_ad_oe;
			bus.br_cbe      <= next_cbe;
			bus.br_cbe_oe   <= next_cbe_oe;
			bus.br_par      <= next_par;
			bus.br_par_oe   <= next_par_oe;
			bus.br_frame_n  <= next_frame_n;
			bus.br_frame_oe <= next_frame_oe;
			bus.br_irdy_n   <= next_irdy_n;
			bus.br_irdy_oe  <= next_irdy_oe;
			done_o          <= next_done;
			done_error_o    <= next_done_error;
			rd_data_o       <= next_rd_data;
		end
	end
endmodule : sb_bridge_end

//--- verilog/sb_pkg.sv
// Shared constants for the secondary bus address/data and command/byte-lane ends
package sb_pkg;
	localparam int          SB_AD_W        = 32;
	localparam int          SB_CBE_W       = 4;
	// Bus commands carried in the address phase
	localparam logic [3:0]  SB_CMD_MEM_RD  = 4'h6;
	localparam logic [3:0]  SB_CMD_MEM_WR  = 4'h7;
	// Level driven while the bridge parks the bus
	localparam logic [31:0] SB_PARK_AD     = 32'h0000_0000;
	localparam logic [3:0]  SB_PARK_CBE    = 4'h0;
	// Request word layout in the FIFO: {write, addr, data, byte_lane_n}
	localparam int          SB_REQ_BE_LSB  = 0;
	localparam int          SB_REQ_DAT_LSB = 4;
	localparam int          SB_REQ_ADR_LSB = 36;
	localparam int          SB_REQ_WR_BIT  = 68;
	localparam int          SB_FIFO_W      = 69;
	localparam int          SB_FIFO_D      = 8;
	// Wait count at which the bridge gives up: six data phase cycles without target ready
	localparam logic [2:0]  SB_WAIT_LIMIT  = 3'h5;
	// Target word store: 16 words, word index from address bits 5:2
	localparam int          SB_MEM_WORDS   = 16;
	localparam int          SB_MEM_IDX_LSB = 2;
	localparam int          SB_MEM_IDX_W   = 4;
endpackage : sb_pkg

//--- verilog/sb_bus_if.sv
// Secondary bus pin carrier: per-party drive with enables, resolved levels
`timescale 1ns/1ps
interface sb_bus_if;
	logic [31:0] br_ad;
	logic        br_ad_oe;
	logic [3:0]  br_cbe;
	logic        br_cbe_oe;
	logic        br_par;
	logic        br_par_oe;
	logic        br_frame_n;
	logic        br_frame_oe;
	logic        br_irdy_n;
	logic        br_irdy_oe;
	logic [31:0] tg_ad;
	logic        tg_ad_oe;
	logic        tg_par;
	logic        tg_par_oe;
	logic        tg_trdy_n;
	logic        tg_trdy_oe;
	logic [31:0] ad;
	logic [3:0]  secondary_cmd_byte_lane_lines;
	logic        secondary_parity_bit;
	logic        frame_n;
	logic        secondary_initiator_ready_n;
	logic        secondary_target_ready_n;

	// Undriven lines read as a weak default: zero for data, high for strobes
	assign ad = br_ad_oe ? br_ad : (tg_ad_oe ? tg_ad : '0);
	assign secondary_cmd_byte_lane_lines = br_cbe_oe ? br_cbe : '0;
	assign secondary_parity_bit = br_par_oe ? br_par : (tg_par_oe ? tg_par : 1'b0);
	assign frame_n = br_frame_oe ? br_frame_n : 1'b1;
	assign secondary_initiator_ready_n = br_irdy_oe ? br_irdy_n : 1'b1;
	assign secondary_target_ready_n = tg_trdy_oe ? tg_trdy_n : 1'b1;

	modport bridge (
		output br_ad, br_ad_oe, br_cbe, br_cbe_oe, br_par, br_par_oe,
		output br_frame_n, br_frame_oe, br_irdy_n, br_irdy_oe,
		input  ad, secondary_cmd_byte_lane_lines, secondary_parity_bit,
		input  frame_n, secondary_initiator_ready_n, secondary_target_ready_n
	);
	modport target (
		output tg_ad, tg_ad_oe, tg_par, tg_par_oe, tg_trdy_n, tg_trdy_oe,
		input  ad, secondary_cmd_byte_lane_lines, secondary_parity_bit,
		input  frame_n, secondary_initiator_ready_n, secondary_target_ready_n
	);
endinterface : sb_bus_if

//--- verilog/sb_target_end.sv
// Far end: secondary bus target with a small word store
`timescale 1ns/1ps
module sb_target_end
	import sb_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	sb_bus_if.target         bus,
	output logic             hit_o,
	output logic             hit_write_o,
	output logic [31:0]      hit_addr_o,
	output logic [31:0]      hit_data_o
);
	typedef enum logic [1:0] {
		SB_TG_IDLE = 2'b00,
		SB_TG_DATA = 2'b01,
		SB_TG_TURN = 2'b10
	} sb_tg_state_t;

	sb_tg_state_t      state;
	sb_tg_state_t      next_state;
	logic [31:0]       mem [0:SB_MEM_WORDS-1];
	logic [31:0]       cur_addr;
	logic              cur_write;
	logic [31:0]       next_cur_addr;
	logic              next_cur_write;
	logic [31:0]       next_ad;
	logic              next_ad_oe;
	logic              next_par;
	logic              next_par_oe;
	logic              next_trdy_n;
	logic              next_trdy_oe;
	logic              next_hit;
	logic [31:0]       next_hit_data;
	logic              addr_seen;
	logic              moved;
	logic [31:0]       merged;
	logic [SB_MEM_IDX_W-1:0] idx;

	always_comb
	begin
		addr_seen      = !bus.frame_n && bus.secondary_initiator_ready_n; // R01
		moved          = !bus.secondary_initiator_ready_n
			&& !bus.secondary_target_ready_n; // R03
		idx            = cur_addr[SB_MEM_IDX_LSB +: SB_MEM_IDX_W];
		next_state     = state;
		next_cur_addr  = cur_addr;
		next_cur_write = cur_write;
		next_ad        = bus.tg_ad;
		next_ad_oe     = bus.tg_ad_oe;
		next_trdy_n    = bus.tg_trdy_n;
		next_trdy_oe   = bus.tg_trdy_oe;
		next_hit       = 1'b0;
		next_hit_data  = hit_data_o;
		next_par       = ^{bus.tg_ad, bus.secondary_cmd_byte_lane_lines}; // R08
		next_par_oe    = bus.tg_ad_oe;
		unique case (state)
			SB_TG_IDLE:
			begin
				next_trdy_oe = 1'b0;
				next_ad_oe   = 1'b0;
				if (addr_seen && (bus.secondary_cmd_byte_lane_lines == SB_CMD_MEM_RD
					|| bus.secondary_cmd_byte_lane_lines == SB_CMD_MEM_WR)) // R05
				begin
					next_state     = SB_TG_DATA;
					next_cur_addr  = bus.ad;
					next_cur_write = (bus.secondary_cmd_byte_lane_lines == SB_CMD_MEM_WR);
					next_trdy_n    = 1'b0;
					next_trdy_oe   = 1'b1;
					next_ad        = mem[bus.ad[SB_MEM_IDX_LSB +: SB_MEM_IDX_W]];
					next_ad_oe     = (bus.secondary_cmd_byte_lane_lines == SB_CMD_MEM_RD);
				end
			end
			SB_TG_DATA:
			begin
				if (moved)
				begin
					next_state    = SB_TG_TURN;
					next_trdy_n   = 1'b1;
					next_ad_oe    = 1'b0;
					next_hit      = 1'b1;
					next_hit_data = bus.ad;
				end
			end
			SB_TG_TURN:
			begin
				next_state   = SB_TG_IDLE;
				next_trdy_oe = 1'b0;
			end
			default:
			begin
				next_state = SB_TG_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state          <= SB_TG_IDLE;
			cur_addr       <= '0;
			cur_write      <= 1'b0;
			bus.tg_ad      <= '0;
			bus.tg_ad_oe   <= 1'b0;
			bus.tg_par     <= 1'b0;
			bus.tg_par_oe  <= 1'b0;
			bus.tg_trdy_n  <= 1'b1;
			bus.tg_trdy_oe <= 1'b0;
			hit_o          <= 1'b0;
			hit_write_o    <= 1'b0;
			hit_addr_o     <= '0;
			hit_data_o     <= '0;
		end
		else
		begin
			state          <= next_state;
			cur_addr       <= next_cur_addr;
			cur_write      <= next_cur_write;
			bus.tg_ad      <= next_ad;
			bus.tg_ad_oe   <= next_ad_oe;
			bus.tg_par     <= next_par;
			bus.tg_par_oe  <= next_par_oe;
			bus.tg_trdy_n  <= next_trdy_n;
			bus.tg_trdy_oe <= next_trdy_oe;
			hit_o          <= next_hit;
			hit_write_o    <= next_hit ? cur_write : hit_write_o;
			hit_addr_o     <= next_hit ? cur_addr : hit_addr_o;
			hit_data_o     <= next_hit_data;
		end
	end

	// Byte lanes are active low; the store has no reset, reads before writes are undefined
	// Lanes merge into one word so the store keeps a single writing process
	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_lane
			assign merged[8*b +: 8] = bus.secondary_cmd_byte_lane_lines[b]
				? mem[idx][8*b +: 8] : bus.ad[8*b +: 8]; // R06
		end
	endgenerate

	always_ff @(posedge sys_clk_i)
	begin
		if (state == SB_TG_DATA && moved && cur_write)
			mem[idx] <= merged;
	end
endmodule : sb_target_end

//--- tb/sb_properties.sv
// Checker for the secondary bus lines between the bridge and target ends
`timescale 1ns/1ps
module sb_properties
	import sb_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        park_grant_i,
	input  wire logic [31:0] br_ad,
	input  wire logic        br_ad_oe,
	input  wire logic [3:0]  br_cbe,
	input  wire logic        br_cbe_oe,
	input  wire logic        br_par_oe,
	input  wire logic        tg_par_oe,
	input  wire logic [31:0] ad,
	input  wire logic [3:0]  secondary_cmd_byte_lane_lines,
	input  wire logic        secondary_parity_bit,
	input  wire logic        frame_n,
	input  wire logic        secondary_initiator_ready_n,
	input  wire logic        secondary_target_ready_n
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	a_addr_cmd_phase: assert property (
		$fell(frame_n) |-> br_ad_oe && br_cbe_oe
			&& (br_cbe == SB_CMD_MEM_RD || br_cbe == SB_CMD_MEM_WR))
		else $error("address phase without command drive");
	a_lanes_follow: assert property (
		!frame_n |=> frame_n && !secondary_initiator_ready_n && br_cbe_oe)
		else $error("no data phase after address phase");
	a_write_stable: assert property (
		!secondary_initiator_ready_n && $past(!secondary_initiator_ready_n) && br_ad_oe
			|-> $stable(br_ad) && $stable(br_cbe))
		else $error("write data moved while initiator ready");
	a_move_ends: assert property (
		!secondary_initiator_ready_n && !secondary_target_ready_n
			|=> secondary_initiator_ready_n && secondary_target_ready_n)
		else $error("readies held after word moved");
	a_wait_bound: assert property (
		$fell(secondary_initiator_ready_n) |-> ##[1:7] secondary_initiator_ready_n)
		else $error("initiator ready held past wait limit");
	// Three idle cycles give the grant sampling time to settle
	a_park_drive: assert property (
		(park_grant_i && frame_n && secondary_initiator_ready_n)[*3]
			|-> br_ad_oe && br_cbe_oe && br_ad == SB_PARK_AD && br_cbe == SB_PARK_CBE)
		else $error("idle bus with grant not parked");
	a_release_idle: assert property (
		(!park_grant_i && frame_n && secondary_initiator_ready_n)[*3]
			|-> !br_ad_oe && !br_cbe_oe)
		else $error("lines driven while idle without grant");
	a_parity_even: assert property (
		br_par_oe || tg_par_oe
			|-> ^{secondary_parity_bit, $past(ad), $past(secondary_cmd_byte_lane_lines)} == 1'b0)
		else $error("parity not even");
endmodule : sb_properties

//--- tb/tb.sv
// Self-checking bench joining the bridge and target ends over the carrier
`timescale 1ns/1ps
module tb
	import sb_pkg::*;
;
	typedef struct packed {logic er; logic wr; logic [31:0] a; logic [31:0] d; logic [3:0] ln;} sb_exp_t;
	logic        sys_clk_i, rst_i, park_grant_i, req_valid_i, req_write_i, tg_rst_i, tmo;
	logic [31:0] req_addr_i, req_data_i, rd_data_o, hit_addr_o, hit_data_o;
	logic [3:0]  req_byte_lane_n_i;
	logic        req_ready_o, done_o, done_error_o, hit_o, hit_write_o;
	sb_exp_t     wq[$], dq[$], hq[$];
	sb_exp_t     cur, e, r;
	logic [31:0] mem [16];
	int          fail_count, samples_checked, seed, n;

	sb_bus_if sb_bus_if_i();
	sb_bridge_end sb_bridge_end_i(.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(sb_bus_if_i),
		.park_grant_i(park_grant_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
		.req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i),
		.req_byte_lane_n_i(req_byte_lane_n_i), .done_o(done_o),
		.done_error_o(done_error_o), .rd_data_o(rd_data_o));
	sb_target_end sb_target_end_i(.sys_clk_i(sys_clk_i), .rst_i(tg_rst_i), .bus(sb_bus_if_i),
		.hit_o(hit_o), .hit_write_o(hit_write_o), .hit_addr_o(hit_addr_o),
		.hit_data_o(hit_data_o));
	sb_properties sb_properties_i(.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.park_grant_i(park_grant_i), .br_ad(sb_bus_if_i.br_ad), .br_ad_oe(sb_bus_if_i.br_ad_oe),
		.br_cbe(sb_bus_if_i.br_cbe), .br_cbe_oe(sb_bus_if_i.br_cbe_oe),
		.br_par_oe(sb_bus_if_i.br_par_oe), .tg_par_oe(sb_bus_if_i.tg_par_oe),
		.ad(sb_bus_if_i.ad), .frame_n(sb_bus_if_i.frame_n),
		.secondary_cmd_byte_lane_lines(sb_bus_if_i.secondary_cmd_byte_lane_lines),
		.secondary_parity_bit(sb_bus_if_i.secondary_parity_bit),
		.secondary_initiator_ready_n(sb_bus_if_i.secondary_initiator_ready_n),
		.secondary_target_ready_n(sb_bus_if_i.secondary_target_ready_n));

	initial
	begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	task chk(input string nm, input logic [31:0] ev, input logic [31:0] sv);
		samples_checked++;
		if (sv !== ev)
		begin
			$display("BAD %s expected %h seen %h", nm, ev, sv);
			fail_count++;
		end
	endtask : chk

	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	// Store model follows each write so later reads know the merged word
	task send(input logic wr, input logic [3:0] idx, input logic [3:0] ln);
		sb_exp_t x;
		int      k;
		x.wr = wr;
		x.er = tmo;
		x.a = $random(seed);
		x.a[5:2] = idx;
		x.ln = ln;
		x.d = wr ? $random(seed) : mem[idx];
		for (k = 0; k < 4; k++)
			if (wr && !ln[k] && !tmo)
				mem[idx][8*k +: 8] = x.d[8*k +: 8];
		req_valid_i = 1'b1;
		req_write_i = wr;
		req_addr_i = x.a;
		req_data_i = x.d;
		req_byte_lane_n_i = ln;
		for (k = 0; k < 200 && req_ready_o !== 1'b1; k++)
			@(negedge sys_clk_i);
		if (k == 200)
			chk("req_ready_wait", 32'h1, 32'h0);
		wq.push_back(x);
		dq.push_back(x);
		if (!tmo)
			hq.push_back(x);
		@(negedge sys_clk_i);
	endtask : send

	task settle;
		int k;
		req_valid_i = 1'b0;
		for (k = 0; k < 2000 && dq.size() > 0; k++)
			@(negedge sys_clk_i);
		if (dq.size() > 0)
		begin
			fail_count++;
			test_done();
		end
		else
			repeat (4) @(negedge sys_clk_i);
	endtask : settle

	always @(negedge sys_clk_i)
		if (rst_i === 1'b0)
		begin
			if (done_o === 1'b1 && dq.size() == 0)
				chk("done_extra", 32'h0, 32'h1);
			else if (done_o === 1'b1)
			begin
				r = dq.pop_front();
				chk("done_error", {31'h0, r.er}, {31'h0, done_error_o});
				if (!r.wr && !r.er)
					chk("rd_data", r.d, rd_data_o);
			end
			if (hit_o === 1'b1 && hq.size() > 0)
			begin
				cur = hq.pop_front();
				chk("hit_write", {31'h0, cur.wr}, {31'h0, hit_write_o});
				chk("hit_addr", cur.a, hit_addr_o);
				chk("hit_data", cur.d, hit_data_o);
			end
			else if (hit_o === 1'b1)
				chk("hit_extra", 32'h0, 32'h1);
			if (sb_bus_if_i.frame_n === 1'b0 && wq.size() > 0)
			begin
				e = wq.pop_front();
				chk("bus_addr", e.a, sb_bus_if_i.ad);
				chk("bus_cmd", {28'h0, e.wr ? SB_CMD_MEM_WR : SB_CMD_MEM_RD},
					{28'h0, sb_bus_if_i.secondary_cmd_byte_lane_lines});
			end
			if (sb_bus_if_i.secondary_initiator_ready_n === 1'b0
				&& sb_bus_if_i.secondary_target_ready_n === 1'b0)
			begin
				chk("bus_lanes", {28'h0, e.ln},
					{28'h0, sb_bus_if_i.secondary_cmd_byte_lane_lines});
				chk("bus_data", e.d, sb_bus_if_i.ad);
			end
		end

	initial
	begin
		repeat (60000) @(posedge sys_clk_i);
		fail_count++;
		test_done();
	end

	initial
	begin
		seed = 9;
		fail_count = 0;
		samples_checked = 0;
		rst_i = 1'b1;
		tg_rst_i = 1'b1;
		tmo = 1'b0;
		park_grant_i = 1'b1;
		req_valid_i = 1'b0;
		req_write_i = 1'b0;
		req_addr_i = 32'h0;
		req_data_i = 32'h0;
		req_byte_lane_n_i = 4'h0;
		repeat (20) @(negedge sys_clk_i);
		rst_i = 1'b0;
		tg_rst_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		// Each word written whole first, since the store has no reset
		for (n = 0; n < 16; n++)
		begin
			send(1'b1, 4'(n), 4'h0);
			send(1'b1, 4'(n), 4'(n));
			send(1'b0, 4'(n), 4'h0);
		end
		settle();
		$display("test lanes done");
		park_grant_i = 1'b0;
		repeat (8) send(1'b1, 4'($random(seed)), 4'($random(seed)));
		repeat (3) @(negedge sys_clk_i);
		chk("req_ready_full", 32'h0, {31'h0, req_ready_o});
		park_grant_i = 1'b1;
		settle();
		$display("test fill done");
		repeat (40) send(1'($random(seed)), 4'($random(seed)), 4'($random(seed)));
		settle();
		$display("test random done");
		// Target held in reset never answers, so the bridge must give up
		tmo = 1'b1;
		tg_rst_i = 1'b1;
		send(1'b1, 4'h3, 4'h0);
		send(1'b0, 4'h3, 4'h0);
		settle();
		tg_rst_i = 1'b0;
		tmo = 1'b0;
		send(1'b0, 4'h3, 4'h0);
		settle();
		$display("test abort done");
		test_done();
	end
endmodule : tb
